// *** accel_consts.svh ***
// Register offsets, field positions and reset values of the accelerometer port
`ifndef ACCEL_CONSTS_SVH
`define ACCEL_CONSTS_SVH

`define RA_STATUS_REG_ALT      8'h18
`define RA_CONTROL_REG_A       8'h1b
`define RA_CONTROL_REG_B       8'h1c
`define RA_CONTROL_REG_C       8'h1d
`define RA_CONTROL_REG_D       8'h1e
`define RA_OFFSET_X            8'h20
`define RA_OFFSET_Y            8'h21
`define RA_OFFSET_Z            8'h22
`define RA_PROG_A_OUTPUT_FLAGS 8'h5f
`define RA_PROG_B_OUTPUT_FLAGS 8'h7f

`define CONTROL_REG_A_DEFAULT  8'h14
`define REG_DEFAULT            8'h00

`define POWER_CONTROL_BIT      7
`define SOFT_RESET_BIT         7
`define PROG_ENABLE_BIT        0

`define SLAVE_ADDR_LOW         7'h1e
`define SLAVE_ADDR_HIGH        7'h1d

`define AHB_IRQ_STATUS         8'h00
`define AHB_IRQ_MASK           8'h04
`define AHB_MODE               8'h08

`define EV_ACTIVE              0
`define EV_STANDBY             1
`define EV_SOFT_RESET          2
`define EV_COUNT               3

`endif

// *** accel_pkg.sv ***
// Types shared by the accelerometer serial port and power-mode logic
package accel_pkg;

    typedef enum logic [3:0]
    {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_RA,
        S_RA_ACK,
        S_WR,
        S_WR_ACK,
        S_RD,
        S_RD_ACK,
        S_IGNORE
    } link_state_t;

endpackage

// *** accel_link.sv ***
// Serial register port, register space and power-mode control of the accelerometer
//
// Operation
// [RULE1] Power-on reset restores status, control, offset and program flag registers, then stand-by
// [RULE2] Power-on reset floats both interrupt pins
// [RULE3] Soft reset acts exactly like power-on reset; here it resets only register space and mode, pins float one cycle later
// [RULE4] Only a serial write of one to the power-control bit enters active mode
// [RULE5] Clearing power-control: stand-by, status to default, pins float, rest kept
// [RULE6] Writing one to the soft-reset bit goes to stand-by like power-on reset
// [RULE7] Enabled programs halt in stand-by and restart from initial state when active
// [RULE8] Device is slave only; never drives clock, start or stop
// [RULE9] A held-low clock stalls the transfer until released
// [RULE10] Bytes are eight bits, most significant first, any number per transfer
// [RULE11] Start is data falling with clock high; stop is data rising with clock high
// [RULE12] First byte holds seven-bit address and direction; answer only own address
// [RULE13] Address is 0011110 with select low, 0011101 with select high
// [RULE14] Receiver drives data low through the acknowledge clock pulse
// [RULE15] Write: address, register address, data; acknowledge all and store data
// [RULE16] Register address advances after each written data byte
// [RULE17] Read: register address, repeated start, read address, device returns data
// [RULE18] Read burst returns sequential registers while master acknowledges
// [RULE19] After a master not-acknowledge, release data until the next start
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "accel_consts.svh"

module accel_link
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic             IRQ,
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE,
    input  wire logic        ADDR_SEL,
    output logic             IRQ_PRIMARY_DATA_READY_O,
    output logic             IRQ_PRIMARY_DATA_READY_OE,
    output logic             IRQ_SECONDARY_O,
    output logic             IRQ_SECONDARY_OE,
    output logic      [1:0]  PROG_RUN,
    output logic      [1:0]  PROG_RESTART
);
    import accel_pkg::*;

    // ********************************
    // Pin synchronisers
    // ********************************
    logic [1:0]  scl_sync_q;
    logic [1:0]  sda_sync_q;
    logic [1:0]  sel_sync_q;
    logic        scl_p_q;
    logic        sda_p_q;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            sel_sync_q <= 2'h0;
            scl_p_q    <= 1'b1;
            sda_p_q    <= 1'b1;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], SCL_I};
            sda_sync_q <= {sda_sync_q[0], SDA_I};
            sel_sync_q <= {sel_sync_q[0], ADDR_SEL};
            scl_p_q    <= scl_sync_q[1];
            sda_p_q    <= sda_sync_q[1];
        end
    end

    logic        scl_s;
    logic        sda_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_ev;
    logic        stop_ev;
    logic [6:0]  own_addr;

    assign scl_s    = scl_sync_q[1];
    assign sda_s    = sda_sync_q[1];
    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s; // RULE11
    assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s; // RULE11
    assign own_addr = sel_sync_q[1] ? `SLAVE_ADDR_HIGH : `SLAVE_ADDR_LOW; // RULE13

    // ********************************
    // Serial slave engine
    // ********************************
    // The clock pin is only ever sampled: the port never stretches and
    // simply waits for the master's next edge.
    link_state_t state_q;
    logic [7:0]  sh_q;
    logic [7:0]  tx_q;
    logic [2:0]  cnt_q;
    logic        got_q;
    logic        mack_q;
    logic [7:0]  ptr_q;
    logic        sda_oe_q;
    logic [7:0]  mem [0:255];

    logic        wr_en;
    logic        soft_rst;
    logic        pc_set;
    logic        pc_clear;
    logic        active_q;

    assign wr_en    = scl_fall & got_q & (state_q == S_WR);
    assign soft_rst = wr_en & (ptr_q == `RA_CONTROL_REG_D) & sh_q[`SOFT_RESET_BIT];
    assign pc_set   = wr_en & (ptr_q == `RA_CONTROL_REG_A) & sh_q[`POWER_CONTROL_BIT] & ~active_q;
    assign pc_clear = wr_en & (ptr_q == `RA_CONTROL_REG_A) & ~sh_q[`POWER_CONTROL_BIT] & active_q;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_q  <= S_IDLE;
            sh_q     <= 8'h00;
            tx_q     <= 8'h00;
            cnt_q    <= 3'h0;
            got_q    <= 1'b0;
            mack_q   <= 1'b0;
            ptr_q    <= 8'h00;
            sda_oe_q <= 1'b0;
        end
        else if (start_ev) // RULE11
        begin
            state_q  <= S_ADDR;
            cnt_q    <= 3'h0;
            got_q    <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else if (stop_ev)
        begin
            state_q  <= S_IDLE;
            sda_oe_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                S_ADDR, S_RA, S_WR:
                begin
                    if (scl_rise) // RULE9
                    begin
                        sh_q  <= {sh_q[6:0], sda_s}; // RULE10
                        cnt_q <= cnt_q + 3'h1;
                        got_q <= (cnt_q == 3'h7);
                    end
                    else if (scl_fall && got_q)
                    begin
                        got_q <= 1'b0;
                        if (state_q == S_ADDR)
                        begin
                            if (sh_q[7:1] == own_addr) // RULE12
                            begin
                                sda_oe_q <= 1'b1; // RULE14
                                state_q  <= S_ADDR_ACK;
                            end
                            else
                            begin
                                state_q <= S_IGNORE;
                            end
                        end
                        else if (state_q == S_RA)
                        begin
                            ptr_q    <= sh_q; // RULE15
                            sda_oe_q <= 1'b1; // RULE14
                            state_q  <= S_RA_ACK;
                        end
                        else
                        begin
                            ptr_q    <= ptr_q + 8'h01; // RULE16
                            sda_oe_q <= 1'b1; // RULE15
                            state_q  <= S_WR_ACK;
                        end
                    end
                end
                S_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (sh_q[0]) // RULE17
                        begin
                            tx_q     <= mem[ptr_q];
                            ptr_q    <= ptr_q + 8'h01;
                            sda_oe_q <= ~mem[ptr_q][7];
                            cnt_q    <= 3'h0;
                            state_q  <= S_RD;
                        end
                        else
                        begin
                            sda_oe_q <= 1'b0;
                            cnt_q    <= 3'h0;
                            state_q  <= S_RA;
                        end
                    end
                end
                S_RA_ACK, S_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_q <= 1'b0;
                        cnt_q    <= 3'h0;
                        state_q  <= S_WR;
                    end
                end
                S_RD:
                begin
                    if (scl_rise)
                    begin
                        cnt_q <= cnt_q + 3'h1;
                        got_q <= (cnt_q == 3'h7);
                    end
                    else if (scl_fall)
                    begin
                        if (got_q)
                        begin
                            got_q    <= 1'b0;
                            sda_oe_q <= 1'b0; // RULE14
                            state_q  <= S_RD_ACK;
                        end
                        else
                        begin
                            tx_q     <= {tx_q[6:0], 1'b0}; // RULE10
                            sda_oe_q <= ~tx_q[6];
                        end
                    end
                end
                S_RD_ACK:
                begin
                    if (scl_rise)
                    begin
                        mack_q <= ~sda_s;
                    end
                    else if (scl_fall)
                    begin
                        if (mack_q) // RULE18
                        begin
                            tx_q     <= mem[ptr_q];
                            ptr_q    <= ptr_q + 8'h01;
                            sda_oe_q <= ~mem[ptr_q][7];
                            cnt_q    <= 3'h0;
                            state_q  <= S_RD;
                        end
                        else
                        begin
                            state_q <= S_IGNORE; // RULE19
                        end
                    end
                end
                default:
                begin
                    sda_oe_q <= 1'b0; // RULE19
                end
            endcase
        end
    end

    // Open drain: the port only ever pulls data low and never touches the clock
    assign SDA_O  = 1'b0; // RULE8
    assign SDA_OE = sda_oe_q;

    // ********************************
    // Register space and power modes
    // ********************************
    always_ff @(posedge CLK)
    begin
        if (RST || soft_rst) // RULE1 RULE3 RULE6
        begin
            mem[`RA_STATUS_REG_ALT]      <= `REG_DEFAULT;
            mem[`RA_CONTROL_REG_A]       <= `CONTROL_REG_A_DEFAULT;
            mem[`RA_CONTROL_REG_B]       <= `REG_DEFAULT;
            mem[`RA_CONTROL_REG_C]       <= `REG_DEFAULT;
            mem[`RA_CONTROL_REG_D]       <= `REG_DEFAULT;
            mem[`RA_OFFSET_X]            <= `REG_DEFAULT;
            mem[`RA_OFFSET_Y]            <= `REG_DEFAULT;
            mem[`RA_OFFSET_Z]            <= `REG_DEFAULT;
            mem[`RA_PROG_A_OUTPUT_FLAGS] <= `REG_DEFAULT;
            mem[`RA_PROG_B_OUTPUT_FLAGS] <= `REG_DEFAULT;
        end
        else
        begin
            if (wr_en)
            begin
                mem[ptr_q] <= sh_q; // RULE15
            end
            if (pc_clear)
            begin
                mem[`RA_STATUS_REG_ALT] <= `REG_DEFAULT; // RULE5
            end
        end
    end

    logic        active_p_q;

    always_ff @(posedge CLK)
    begin
        if (RST || soft_rst) // RULE1 RULE3 RULE6
        begin
            active_q <= 1'b0;
        end
        else if (pc_set || pc_clear) // RULE4 RULE5
        begin
            active_q <= pc_set;
        end
    end

    // ********************************
    // Programs and interrupt pins
    // ********************************
    logic [1:0]  prog_en;
    logic [1:0]  pin_oe_q;
    logic [1:0]  pin_val_q;

    assign prog_en[0] = mem[`RA_CONTROL_REG_B][`PROG_ENABLE_BIT];
    assign prog_en[1] = mem[`RA_CONTROL_REG_C][`PROG_ENABLE_BIT];

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            active_p_q <= 1'b0;
        end
        else
        begin
            active_p_q <= active_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_prog
            always_ff @(posedge CLK)
            begin
                if (RST)
                begin
                    PROG_RUN[gi]     <= 1'b0;
                    PROG_RESTART[gi] <= 1'b0;
                    pin_oe_q[gi]     <= 1'b0;
                    pin_val_q[gi]    <= 1'b0;
                end
                else
                begin
                    PROG_RUN[gi]     <= active_q & prog_en[gi]; // RULE7
                    PROG_RESTART[gi] <= active_q & ~active_p_q & prog_en[gi]; // RULE7
                    pin_oe_q[gi]     <= active_q; // RULE2 RULE5
                    pin_val_q[gi]    <= (gi == 0) ? |mem[`RA_PROG_A_OUTPUT_FLAGS]
                                                  : |mem[`RA_PROG_B_OUTPUT_FLAGS];
                end
            end
        end
    endgenerate

    assign IRQ_PRIMARY_DATA_READY_O  = pin_val_q[0];
    assign IRQ_PRIMARY_DATA_READY_OE = pin_oe_q[0];
    assign IRQ_SECONDARY_O           = pin_val_q[1];
    assign IRQ_SECONDARY_OE          = pin_oe_q[1];

    // ********************************
    // Bus slave and interrupt
    // ********************************
    // Reads take one wait state so a write just before is already visible.
    logic [`EV_COUNT-1:0] ev;
    logic [`EV_COUNT-1:0] irq_stat_q;
    logic [`EV_COUNT-1:0] irq_mask_q;
    logic [`EV_COUNT-1:0] w1c;
    logic        wr_pend_q;
    logic        rd_wait_q;
    logic [7:0]  baddr_q;
    logic        take;

    assign take = HSEL & HREADY & HTRANS[1];
    assign ev   = {soft_rst, pc_clear, pc_set};
    assign w1c  = (wr_pend_q && baddr_q == `AHB_IRQ_STATUS) ? HWDATA[`EV_COUNT-1:0] : '0;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            wr_pend_q <= 1'b0;
            rd_wait_q <= 1'b0;
            baddr_q   <= 8'h00;
        end
        else
        begin
            wr_pend_q <= take & HWRITE;
            rd_wait_q <= take & ~HWRITE;
            if (take)
            begin
                baddr_q <= HADDR[7:0];
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            IRQ        <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~w1c) | ev;
            if (wr_pend_q && baddr_q == `AHB_IRQ_MASK)
            begin
                irq_mask_q <= HWDATA[`EV_COUNT-1:0];
            end
            IRQ <= |(irq_stat_q & irq_mask_q);
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            HRDATA <= 32'h0000_0000;
        end
        else if (rd_wait_q)
        begin
            case (baddr_q)
                `AHB_IRQ_STATUS: HRDATA <= {29'h0, irq_stat_q};
                `AHB_IRQ_MASK:   HRDATA <= {29'h0, irq_mask_q};
                `AHB_MODE:       HRDATA <= {29'h0, state_q != S_IDLE, sel_sync_q[1], active_q};
                default:         HRDATA <= 32'h0000_0000;
            endcase
        end
    end

    assign HREADYOUT = ~rd_wait_q;
    assign HRESP     = 1'b0;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (1'b0);

    property p_por_defaults;
        RST |=> !active_q && mem[`RA_CONTROL_REG_A] == `CONTROL_REG_A_DEFAULT;
    endproperty
    a_por_defaults: assert property (p_por_defaults) else $error("Reset left wrong mode"); // RULE1

    property p_por_pins;
        RST |=> !IRQ_PRIMARY_DATA_READY_OE && !IRQ_SECONDARY_OE;
    endproperty
    a_por_pins: assert property (p_por_pins) else $error("Pins driven after reset"); // RULE2

    property p_soft_reset;
        disable iff (RST) soft_rst |=> !active_q && mem[`RA_CONTROL_REG_D] == `REG_DEFAULT ##1 !pin_oe_q[0];
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("Soft reset incomplete"); // RULE3

    property p_only_path;
        disable iff (RST) !active_q && !pc_set |=> !active_q;
    endproperty
    a_only_path: assert property (p_only_path) else $error("Active without command"); // RULE4

    property p_pc_clear;
        disable iff (RST) pc_clear |=> !active_q && mem[`RA_STATUS_REG_ALT] == `REG_DEFAULT
            && mem[`RA_OFFSET_X] == $past(mem[`RA_OFFSET_X]) ##1 !pin_oe_q[1];
    endproperty
    a_pc_clear: assert property (p_pc_clear) else $error("Stand-by entry wrong"); // RULE5

    property p_restart;
        disable iff (RST) PROG_RESTART[0] |-> PROG_RUN[0] && $past(!active_q, 2);
    endproperty
    a_restart: assert property (p_restart) else $error("Restart without wake"); // RULE7

    property p_foreign;
        disable iff (RST) state_q == S_ADDR && scl_fall && got_q && sh_q[7:1] != own_addr && !stop_ev
            |=> state_q == S_IGNORE && !sda_oe_q;
    endproperty
    a_foreign: assert property (p_foreign) else $error("Answered foreign address"); // RULE12

    property p_ack_drive;
        disable iff (RST) (state_q == S_RA_ACK || state_q == S_WR_ACK) |-> SDA_OE && !SDA_O;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("Acknowledge not driven"); // RULE14

    property p_advance;
        disable iff (RST) wr_en |=> ptr_q == $past(ptr_q) + 8'h01;
    endproperty
    a_advance: assert property (p_advance) else $error("Address not advanced"); // RULE16

    property p_release;
        disable iff (RST) state_q == S_IGNORE |-> !sda_oe_q;
    endproperty
    a_release: assert property (p_release) else $error("Data driven while idle"); // RULE19

endmodule

// *** accel_bus_master.sv ***
// Two-wire serial bus master model that drives the accelerometer port
`timescale 1ns/1ps
module accel_bus_master
(
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_m
);
    // Only this model drives the clock, so there is no held-low clock to wait on
    initial
    begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    task q(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Values change right after an edge and hold n cycles
    task drv(input logic c, input logic d, input int n);
        @(posedge clk);
        scl   <= c;
        sda_m <= d;
        q(n - 1);
    endtask

    // Also a repeated start when entered with the clock low
    task start;
        drv(scl, 1'b1, 2);
        drv(1'b1, 1'b1, 3);
        drv(1'b1, 1'b0, 3);
        drv(1'b0, 1'b0, 3);
    endtask

    task stop;
        drv(1'b0, 1'b0, 2);
        drv(1'b1, 1'b0, 3);
        drv(1'b1, 1'b1, 3);
    endtask

    // Clock low 5 cycles so the slave's delayed data settles before the rise
    task bit_io(input logic b, output logic r);
        drv(1'b0, b, 2);
        drv(1'b1, b, 3);
        @(negedge clk);
        r = sda;
        drv(1'b0, b, 3);
    endtask

    task wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(nack, r);
    endtask
endmodule

// *** test_accel_i2c_slave_power_modes.sv ***
// Self-checking bench of the accelerometer serial port and power modes
`timescale 1ns/1ps
module test_accel_i2c_slave_power_modes;
    logic        clk, rst, hsel, hwrite, addr_sel, hreadyout, hresp, irq, sda_o, sda_oe, a;
    logic        p_o, p_oe, s_o, s_oe, scl, sda_m;
    logic [1:0]  htrans, prog_run, prog_restart;
    logic [6:0]  sad;
    logic [31:0] haddr, hwdata, hrdata, rd, x;
    logic [7:0]  wb[3], rb[4], ofs[3];
    int          fails, num_checks, rcnt;
    wire         sda = sda_m & (sda_oe ? sda_o : 1'b1);

    accel_link dut
    (
        .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .IRQ(irq),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_SEL(addr_sel),
        .IRQ_PRIMARY_DATA_READY_O(p_o), .IRQ_PRIMARY_DATA_READY_OE(p_oe), .IRQ_SECONDARY_O(s_o),
        .IRQ_SECONDARY_OE(s_oe), .PROG_RUN(prog_run), .PROG_RESTART(prog_restart)
    );
    accel_bus_master m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Restart pulses are one cycle wide, so they are counted rather than sampled
    always @(posedge clk) rcnt <= rst ? 0 : rcnt + prog_restart[0] + prog_restart[1];

    function logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function logic [31:0] mode_exp(input logic act, input logic sel);
        return {30'h0, sel, act};
    endfunction

    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wait_rdy(output logic [31:0] d);
        int n;
        n = 0;
        @(negedge clk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                fails++;
                finish_test;
            end
            @(negedge clk);
        end
        d = hrdata;
        @(posedge clk);
    endtask

    task ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] d);
        @(posedge clk);
        haddr  <= {24'h0, ad};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy(d);
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy(d);
    endtask

    task idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task sw(input logic [7:0] ra, input int n);
        m.start;
        m.wbyte({sad, 1'b0}, a);
        chk({31'h0, a}, 1);
        m.wbyte(ra, a);
        chk({31'h0, a}, 1);
        for (int i = 0; i < n; i++)
        begin
            m.wbyte(wb[i], a);
            chk({31'h0, a}, 1);
        end
        m.stop;
    endtask

    task sr(input logic [7:0] ra, input int n);
        m.start;
        m.wbyte({sad, 1'b0}, a);
        m.wbyte(ra, a);
        m.start;
        m.wbyte({sad, 1'b1}, a);
        chk({31'h0, a}, 1);
        for (int i = 0; i < n; i++)
            m.rbyte(i == n - 1, rb[i]);
        m.stop;
        @(negedge clk);
        chk({31'h0, sda_oe}, 0);
    endtask

    task chk_def;
        sr(8'h18, 1);
        chk({24'h0, rb[0]}, 0);
        sr(8'h1b, 4);
        chk({rb[0], rb[1], rb[2], rb[3]}, 32'h14000000);
        sr(8'h20, 3);
        chk({8'h0, rb[0], rb[1], rb[2]}, 0);
        chk({28'h0, p_oe, s_oe, prog_run}, 0);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        x = 32'h6b4898fa;
        fails = 0;
        num_checks = 0;
        rst = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        addr_sel = 1'b0;
        sad = 7'h1e;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        ahb(1'b1, 8'h08, 32'h1, rd);
        ahb(1'b0, 8'h08, 32'h0, rd);
        chk(rd, mode_exp(1'b0, 1'b0));
        ahb(1'b0, 8'h0c, 32'h0, rd);
        chk({rd[31:1], hresp}, 0);
        chk_def;
        for (int s = 0; s < 2; s++)
        begin
            @(posedge clk);
            addr_sel <= s[0];
            sad = s[0] ? 7'h1d : 7'h1e;
            m.q(8);
            m.start;
            m.wbyte({s[0] ? 7'h1e : 7'h1d, 1'b0}, a);
            chk({31'h0, a}, 0);
            m.stop;
            ahb(1'b0, 8'h08, 32'h0, rd);
            chk(rd, mode_exp(1'b0, s[0]));
            for (int i = 0; i < 3; i++)
            begin
                x = lfsr(x);
                ofs[i] = x[7:0];
                wb[i] = x[7:0];
            end
            sw(8'h20, 3);
            sr(8'h20, 3);
            chk({rb[0], rb[1], rb[2]}, {ofs[0], ofs[1], ofs[2]});
        end
        // ****************************************
        // Power modes and events
        // ****************************************
        ahb(1'b1, 8'h04, 32'h7, rd);
        wb[0] = 8'h01;
        wb[1] = 8'h01;
        sw(8'h1c, 2);
        wb[0] = 8'h94;
        sw(8'h1b, 1);
        idle(4);
        chk({25'h0, irq, p_oe, s_oe, p_o, s_o, prog_run}, 32'h73);
        chk(rcnt, 2);
        ahb(1'b0, 8'h00, 32'h0, rd);
        chk(rd, 1);
        ahb(1'b1, 8'h00, 32'h1, rd);
        ahb(1'b1, 8'h04, 32'h0, rd);
        wb[0] = 8'h5a;
        sw(8'h18, 1);
        wb[0] = 8'h14;
        sw(8'h1b, 1);
        idle(4);
        chk({25'h0, irq, p_oe, s_oe, p_o, s_o, prog_run}, 0);
        ahb(1'b0, 8'h00, 32'h0, rd);
        chk(rd, 2);
        sr(8'h18, 1);
        chk({24'h0, rb[0]}, 0);
        sr(8'h1c, 2);
        chk({16'h0, rb[0], rb[1]}, 32'h0101);
        ahb(1'b1, 8'h04, 32'h7, rd);
        idle(2);
        chk({31'h0, irq}, 1);
        ahb(1'b1, 8'h00, 32'h7, rd);
        idle(2);
        chk({31'h0, irq}, 0);
        wb[0] = 8'h94;
        sw(8'h1b, 1);
        idle(4);
        chk(rcnt, 4);
        wb[0] = 8'h80;
        sw(8'h1e, 1);
        idle(4);
        ahb(1'b0, 8'h00, 32'h0, rd);
        chk({30'h0, rd[2], irq}, 3);
        ahb(1'b0, 8'h08, 32'h0, rd);
        chk(rd, mode_exp(1'b0, 1'b1));
        chk_def;
        finish_test;
    end
endmodule
